// ==== hdl/loop_defines.svh ====
// Constants for the serial-loop message responder and poll status logic
// Contract
// (R1) Device clear empties queues, aborts measurement, restores normal mode, leaves direct mode.
// (R2) REN puts the instrument in the remote-enabled state.
// (R3) GTL switches to local, only while listen addressed.
// (R4) LLO enters local lockout only when already remote enabled.
// (R5) NRE returns to local and clears any lockout.
// (R6) A serial poll returns the present status byte over the loop.
// (R7) PPC arms programming; next PPE programs, PPD disables; otherwise ignored.
// (R8) PPU always disables the response; PPD acts only when listen addressed.
// (R9) Parallel poll inserts service status when enabled, else passes byte unchanged.
// (R10) Own listen address makes listener active, and remote if remote enabled.
// (R11) UNL drops listener-active status.
// (R12) Own talk address makes talker active; other talk address drops talker.
// (R13) UNT drops talker-active status.
// (R14) Group execute trigger and loop power-down are ignored.
// (R15) After EAR, instrument data causes an IDY request until another command.
// (R16) Status byte has bit 7 set, bit 6 service request, low six code.
// (R17) Event codes clear on serial poll; state codes follow instrument state only.
// (R18) When output data ceases, data-ready code becomes the all-OK code; the master/slave code shows while ms_link is high with no event or data pending.
// (R19) Codes: OK, master/slave, invalid, self-test, command error, panel, data ready.
// (R20) The status byte is refreshed whenever instrument status changes.
// (R21) PPE form 1000SBBB: S is sense, BBB selects response bit 0 to 7.
// (R22) PPE is ignored unless the module is listen addressed.
// (R23) Interface clear drops all addressing but keeps queued data.
// (R24) In data service-request mode, data sets request bit and data code.
`ifndef LOOP_DEFINES_SVH
`define LOOP_DEFINES_SVH

// Status byte layout
`define STAT_TOP_BIT 7
`define STAT_SRQ_BIT 6
`define STAT_STATE_BIT 5
`define STAT_RESET_BYTE 8'h80

// Six-bit status codes
`define CODE_ALL_OK 6'h00
`define CODE_MS_LINK 6'h23
`define CODE_INVALID 6'h04
`define CODE_SELF_TEST 6'h06
`define CODE_CMD_ERROR 6'h07
`define CODE_PANEL_REQ 6'h09
`define CODE_DATA_READY 6'h22

// Parallel poll enable data field 1000SBBB
`define PPE_FORM_NIBBLE 4'h8
`define PPE_SENSE_BIT 3
`define PPE_SEL_MSB 2
`define PPE_SEL_LSB 0

`endif

// ==== hdl/loop_pkg.sv ====
// Types shared by the loop responder
package loop_pkg;

	// Decoded loop message classes delivered by the frame receiver
	typedef enum logic [4:0] {
		MSG_IFC, MSG_SDC, MSG_DCL, MSG_REN, MSG_GTL, MSG_LLO, MSG_NRE,
		MSG_PPC, MSG_PPE, MSG_PPD, MSG_PPU, MSG_LAD, MSG_UNL, MSG_TAD,
		MSG_UNT, MSG_GET, MSG_EAR, MSG_LPD, MSG_OTHER
	} msg_kind_t;

	// Parallel poll configuration sequencer
	typedef enum logic [0:0] {
		PP_IDLE,
		PP_ARMED
	} pp_cfg_state_t;

endpackage

// ==== hdl/loop_poll_responder.sv ====
// Message responder, addressing state and poll status logic of the loop interface module
`timescale 1ns/1ps
`default_nettype none
`include "loop_defines.svh"

module loop_poll_responder #(
	parameter int ADDR_W = 5
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic msg_valid,
	input wire loop_pkg::msg_kind_t msg_kind,
	input wire logic [7:0] msg_data,
	input wire logic [ADDR_W-1:0] own_addr,
	input wire logic spoll_req,
	input wire logic pp_valid,
	input wire logic [7:0] pp_byte_in,
	input wire logic inst_event_valid,
	input wire logic [5:0] inst_event_code,
	input wire logic data_avail,
	input wire logic data_push,
	input wire logic ms_link,
	input wire logic srq_on_data_mode,
	output logic remote_en_reg,
	output logic remote_reg,
	output logic lockout_reg,
	output logic listen_reg,
	output logic talk_reg,
	output logic clear_reg,
	output logic idy_req_reg,
	output logic spoll_valid_reg,
	output logic [7:0] spoll_byte_reg,
	output logic [7:0] poll_status_byte_reg,
	output logic pp_out_valid_reg,
	output logic [7:0] pp_byte_out_reg,
	output logic pp_en_reg
);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Address compare, used for both listen and talk addresses
	function automatic logic addr_match(input logic [7:0] data, input logic [ADDR_W-1:0] addr);
		addr_match = (data[ADDR_W-1:0] == addr);
	endfunction

	// One-hot mask for the selected parallel poll response bit
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction

	// ****************************************************************
	// Addressing and remote/local state
	// ****************************************************************

	logic remote_en_next;
	logic remote_next;
	logic lockout_next;
	logic listen_next;
	logic talk_next;
	logic clear_next;

	// Only one message arrives per cycle, so the case needs no priority among messages
	always_comb begin
		remote_en_next = remote_en_reg;
		remote_next = remote_reg;
		lockout_next = lockout_reg;
		listen_next = listen_reg;
		talk_next = talk_reg;
		clear_next = 1'b0;
		if (msg_valid) begin
			case (msg_kind)
				loop_pkg::MSG_IFC: begin
					// Queued data is untouched; only addressing drops
					listen_next = 1'b0; // R23
					talk_next = 1'b0; // R23
				end
				loop_pkg::MSG_SDC: begin
					clear_next = listen_reg; // R1
				end
				loop_pkg::MSG_DCL: begin
					clear_next = 1'b1; // R1
				end
				loop_pkg::MSG_REN: begin
					remote_en_next = 1'b1; // R2
				end
				loop_pkg::MSG_GTL: begin
					if (listen_reg) begin
						remote_next = 1'b0; // R3
					end
				end
				loop_pkg::MSG_LLO: begin
					if (remote_en_reg) begin
						lockout_next = 1'b1; // R4
					end
				end
				loop_pkg::MSG_NRE: begin
					remote_en_next = 1'b0;
					remote_next = 1'b0; // R5
					lockout_next = 1'b0; // R5
				end
				loop_pkg::MSG_LAD: begin
					if (addr_match(msg_data, own_addr)) begin
						listen_next = 1'b1; // R10
						if (remote_en_reg) begin
							remote_next = 1'b1; // R10
						end
					end
				end
				loop_pkg::MSG_UNL: begin
					listen_next = 1'b0; // R11
				end
				loop_pkg::MSG_TAD: begin
					// Another device's talk address takes the talker role away
					talk_next = addr_match(msg_data, own_addr); // R12
				end
				loop_pkg::MSG_UNT: begin
					talk_next = 1'b0; // R13
				end
				loop_pkg::MSG_GET, loop_pkg::MSG_LPD: begin
					// No trigger or power-down capability
					clear_next = 1'b0; // R14
				end
				default: begin
					clear_next = 1'b0;
				end
			endcase
		end
	end

	// Register the addressing state
	always_ff @(posedge clk) begin
		if (!nrst) begin
			remote_en_reg <= 1'b0;
			remote_reg <= 1'b0;
			lockout_reg <= 1'b0;
			listen_reg <= 1'b0;
			talk_reg <= 1'b0;
			clear_reg <= 1'b0;
		end else begin
			remote_en_reg <= remote_en_next;
			remote_reg <= remote_next;
			lockout_reg <= lockout_next;
			listen_reg <= listen_next;
			talk_reg <= talk_next;
			clear_reg <= clear_next;
		end
	end

	// ****************************************************************
	// Asynchronous request mode
	// ****************************************************************

	logic ear_mode_reg;
	logic ear_mode_next;
	logic idy_req_next;

	// Any message other than EAR itself ends the mode
	always_comb begin
		ear_mode_next = ear_mode_reg;
		if (msg_valid) begin
			ear_mode_next = (msg_kind == loop_pkg::MSG_EAR); // R15
		end
		idy_req_next = ear_mode_reg && data_push; // R15
	end

	// Register the request mode
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ear_mode_reg <= 1'b0;
			idy_req_reg <= 1'b0;
		end else begin
			ear_mode_reg <= ear_mode_next;
			idy_req_reg <= idy_req_next;
		end
	end

	// ****************************************************************
	// Serial poll status
	// ****************************************************************

	logic event_pend_reg;
	logic event_pend_next;
	logic [5:0] event_code_reg;
	logic [5:0] event_code_next;
	logic [7:0] status_byte_next;
	logic spoll_valid_next;
	logic [7:0] spoll_byte_next;
	logic stat_srq;
	logic [5:0] stat_code;

	// An event landing in the poll cycle survives: the set is applied after the clear
	always_comb begin
		event_pend_next = event_pend_reg;
		event_code_next = event_code_reg;
		if (spoll_req) begin
			event_pend_next = 1'b0; // R17
		end
		if (inst_event_valid) begin
			event_pend_next = 1'b1;
			event_code_next = inst_event_code;
		end
		// Events outrank states; state codes track the inputs directly
		if (event_pend_reg) begin
			stat_code = event_code_reg;
			stat_srq = 1'b1;
		end else if (data_avail) begin
			stat_code = `CODE_DATA_READY; // R19
			stat_srq = srq_on_data_mode; // R24
		end else if (ms_link) begin
			stat_code = `CODE_MS_LINK; // R19
			stat_srq = 1'b0;
		end else begin
			// Data gone: falls back to all OK without waiting for a poll
			stat_code = `CODE_ALL_OK; // R18
			stat_srq = 1'b0;
		end
		status_byte_next = {1'b1, stat_srq, stat_code}; // R16
		spoll_valid_next = spoll_req; // R6
		spoll_byte_next = spoll_req ? poll_status_byte_reg : spoll_byte_reg; // R6
	end

	// Status byte refreshes every cycle from the instrument status
	always_ff @(posedge clk) begin
		if (!nrst) begin
			event_pend_reg <= 1'b0;
			event_code_reg <= `CODE_ALL_OK;
			poll_status_byte_reg <= `STAT_RESET_BYTE;
			spoll_valid_reg <= 1'b0;
			spoll_byte_reg <= `STAT_RESET_BYTE;
		end else begin
			event_pend_reg <= event_pend_next;
			event_code_reg <= event_code_next;
			poll_status_byte_reg <= status_byte_next; // R20
			spoll_valid_reg <= spoll_valid_next;
			spoll_byte_reg <= spoll_byte_next;
		end
	end

	// ****************************************************************
	// Parallel poll
	// ****************************************************************

	loop_pkg::pp_cfg_state_t pp_state_reg;
	loop_pkg::pp_cfg_state_t pp_state_next;
	logic pp_en_next;
	logic pp_sense_reg;
	logic pp_sense_next;
	logic [2:0] poll_response_bit_select_reg;
	logic [2:0] poll_response_bit_select_next;
	logic pp_out_valid_next;
	logic [7:0] pp_byte_out_next;
	logic pp_assert;

	// Configure sequence: PPC must be the message right before PPE or PPD
	always_comb begin
		pp_state_next = pp_state_reg;
		pp_en_next = pp_en_reg;
		pp_sense_next = pp_sense_reg;
		poll_response_bit_select_next = poll_response_bit_select_reg;
		if (msg_valid) begin
			pp_state_next = loop_pkg::PP_IDLE; // R7
			case (pp_state_reg)
				loop_pkg::PP_IDLE: begin
					if (msg_kind == loop_pkg::MSG_PPC && listen_reg) begin
						pp_state_next = loop_pkg::PP_ARMED; // R7
					end
				end
				loop_pkg::PP_ARMED: begin
					if (msg_kind == loop_pkg::MSG_PPE && listen_reg &&
						msg_data[7:4] == `PPE_FORM_NIBBLE) begin
						pp_en_next = 1'b1; // R22
						pp_sense_next = msg_data[`PPE_SENSE_BIT]; // R21
						poll_response_bit_select_next = msg_data[`PPE_SEL_MSB:`PPE_SEL_LSB]; // R21
					end else if (msg_kind == loop_pkg::MSG_PPD && listen_reg) begin
						pp_en_next = 1'b0; // R8
					end else if (msg_kind == loop_pkg::MSG_PPC && listen_reg) begin
						pp_state_next = loop_pkg::PP_ARMED;
					end
				end
				default: begin
					pp_state_next = loop_pkg::PP_IDLE;
				end
			endcase
			if (msg_kind == loop_pkg::MSG_PPU) begin
				pp_en_next = 1'b0; // R8
			end
		end
		// Sense 1 answers on need of service, sense 0 on no need
		pp_assert = pp_en_reg && (pp_sense_reg == poll_status_byte_reg[`STAT_SRQ_BIT]); // R9
		pp_out_valid_next = pp_valid;
		pp_byte_out_next = pp_byte_out_reg;
		if (pp_valid) begin
			pp_byte_out_next = pp_assert ?
				(pp_byte_in | bit_mask(poll_response_bit_select_reg)) : pp_byte_in; // R9
		end
	end

	// Register the parallel poll configuration and the passing byte
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pp_state_reg <= loop_pkg::PP_IDLE;
			pp_en_reg <= 1'b0;
			pp_sense_reg <= 1'b0;
			poll_response_bit_select_reg <= 3'h0;
			pp_out_valid_reg <= 1'b0;
			pp_byte_out_reg <= 8'h00;
		end else begin
			pp_state_reg <= pp_state_next;
			pp_en_reg <= pp_en_next;
			pp_sense_reg <= pp_sense_next;
			poll_response_bit_select_reg <= poll_response_bit_select_next;
			pp_out_valid_reg <= pp_out_valid_next;
			pp_byte_out_reg <= pp_byte_out_next;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************

	// Device clear pulses once on DCL; a message right behind it may extend the pulse
	AST_DCL_CLEARS: assert property (@(posedge clk) disable iff (!nrst) // R1
		msg_valid && msg_kind == loop_pkg::MSG_DCL |=> clear_reg ##1 (!clear_reg || $past(msg_valid)))
		else $error("device clear pulse missing");

	// Lockout can only rise while remote enabled
	AST_LLO_NEEDS_REN: assert property (@(posedge clk) disable iff (!nrst) // R4
		$rose(lockout_reg) |-> $past(remote_en_reg))
		else $error("lockout without remote enable");

	// NRE leaves the instrument local and unlocked
	AST_NRE_LOCAL: assert property (@(posedge clk) disable iff (!nrst) // R5
		msg_valid && msg_kind == loop_pkg::MSG_NRE |=> !remote_reg && !lockout_reg)
		else $error("NRE did not return to local");

	// GTL ignored while not listen addressed
	AST_GTL_UNADDR: assert property (@(posedge clk) disable iff (!nrst) // R3
		msg_valid && msg_kind == loop_pkg::MSG_GTL && !listen_reg |=> $stable(remote_reg))
		else $error("GTL acted while unaddressed");

	// Serial poll answers with the byte standing at the request
	AST_SPOLL_BYTE: assert property (@(posedge clk) disable iff (!nrst) // R6
		spoll_req |=> spoll_valid_reg && spoll_byte_reg == $past(poll_status_byte_reg))
		else $error("serial poll byte wrong");

	// Every status byte carries the system-status marker
	AST_TOP_BIT: assert property (@(posedge clk) disable iff (!nrst) // R16
		poll_status_byte_reg[`STAT_TOP_BIT])
		else $error("status byte bit 7 clear");

	// Orphan PPE leaves the response untouched
	AST_PPE_ORPHAN: assert property (@(posedge clk) disable iff (!nrst) // R7
		msg_valid && msg_kind == loop_pkg::MSG_PPE && pp_state_reg == loop_pkg::PP_IDLE
		|=> $stable(pp_en_reg) && $stable(poll_response_bit_select_reg))
		else $error("PPE without PPC took effect");

	// PPU disables regardless of addressing
	AST_PPU_OFF: assert property (@(posedge clk) disable iff (!nrst) // R8
		msg_valid && msg_kind == loop_pkg::MSG_PPU |=> !pp_en_reg)
		else $error("PPU did not disable");

	// Disabled response forwards the poll byte untouched
	AST_PP_PASS: assert property (@(posedge clk) disable iff (!nrst) // R9
		pp_valid && !pp_en_reg |=> pp_out_valid_reg && pp_byte_out_reg == $past(pp_byte_in))
		else $error("poll byte modified while disabled");

	// UNT always drops the talker
	AST_UNT_DROP: assert property (@(posedge clk) disable iff (!nrst) // R13
		msg_valid && msg_kind == loop_pkg::MSG_UNT |=> !talk_reg)
		else $error("talker kept after UNT");

	// EAR mode turns instrument data into one IDY request
	AST_EAR_IDY: assert property (@(posedge clk) disable iff (!nrst) // R15
		ear_mode_reg && data_push |=> idy_req_reg)
		else $error("IDY request missing");

	// An event seen in the poll cycle is not lost
	AST_EVENT_KEEP: assert property (@(posedge clk) disable iff (!nrst) // R17
		inst_event_valid |=> event_pend_reg ##1 poll_status_byte_reg[5:0] == $past(event_code_reg))
		else $error("event code lost");

endmodule

`default_nettype wire

// ==== tb/loop_ctl_model.sv ====
// Loop controller model: drives decoded messages and polls into the responder
`timescale 1ns/1ps
`default_nettype none

module loop_ctl_model (
	input wire logic clk,
	output var logic msg_valid,
	output var loop_pkg::msg_kind_t msg_kind,
	output var logic [7:0] msg_data,
	output var logic spoll_req,
	output var logic pp_valid,
	output var logic [7:0] pp_byte_in
);
	// Idle levels from time zero
	initial begin
		msg_valid = 1'b0;
		msg_kind = loop_pkg::MSG_OTHER;
		msg_data = 8'h00;
		spoll_req = 1'b0;
		pp_valid = 1'b0;
		pp_byte_in = 8'h00;
	end

	// One message, held until the edge that takes it
	task automatic send(input loop_pkg::msg_kind_t k, input logic [7:0] d);
		msg_kind = k;
		msg_data = d;
		msg_valid = 1'b1;
		@(posedge clk);
		#1;
		msg_valid = 1'b0;
		msg_data = ~d; // Released data must not look valid
	endtask

	// Serial poll (par low) or parallel poll with a passing byte
	task automatic poll(input logic par, input logic [7:0] b);
		pp_byte_in = b;
		pp_valid = par;
		spoll_req = ~par;
		@(posedge clk);
		#1;
		pp_valid = 1'b0;
		spoll_req = 1'b0;
		pp_byte_in = ~b;
	endtask

	// Enable byte layout 1000SBBB
	function automatic logic [7:0] ppe_byte(input logic s, input logic [2:0] b);
		return {4'h8, s, b};
	endfunction
endmodule
`default_nettype wire

// ==== tb/tb_loop_poll_responder.sv ====
// Self-checking bench for the loop message responder
`timescale 1ns/1ps
`default_nettype none

module tb_loop_poll_responder;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] own_addr = 5'h03;
	logic inst_event_valid = 1'b0;
	logic [5:0] inst_event_code = 6'h00;
	logic data_avail = 1'b0;
	logic data_push = 1'b0;
	logic ms_link = 1'b0;
	logic srq_on_data_mode = 1'b0;
	logic msg_valid, spoll_req, pp_valid;
	loop_pkg::msg_kind_t msg_kind;
	logic [7:0] msg_data, pp_byte_in;
	logic remote_en_reg, remote_reg, lockout_reg, listen_reg, talk_reg, clear_reg;
	logic idy_req_reg, spoll_valid_reg, pp_out_valid_reg, pp_en_reg;
	logic [7:0] spoll_byte_reg, poll_status_byte_reg, pp_byte_out_reg;
	int n_mismatch = 0;
	int cmp_count = 0;
	// Reference model state
	bit ren, rem, llo, lis, tlk, ppen, sns, armed;
	int pbit = 0;
	int ev = -1;
	logic [7:0] d;

	loop_ctl_model ctl (.clk, .msg_valid, .msg_kind, .msg_data, .spoll_req, .pp_valid,
		.pp_byte_in);
	loop_poll_responder dut (.clk, .nrst, .msg_valid, .msg_kind, .msg_data, .own_addr,
		.spoll_req, .pp_valid, .pp_byte_in, .inst_event_valid, .inst_event_code, .data_avail,
		.data_push, .ms_link, .srq_on_data_mode, .remote_en_reg, .remote_reg, .lockout_reg,
		.listen_reg, .talk_reg, .clear_reg, .idy_req_reg, .spoll_valid_reg, .spoll_byte_reg,
		.poll_status_byte_reg, .pp_out_valid_reg, .pp_byte_out_reg, .pp_en_reg);

	// 10 MHz clock
	always #50 clk = ~clk;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Expected live status: pending event, then data, then link state
	function automatic logic [7:0] st();
		if (ev >= 0) return {2'b11, 6'(ev)};
		if (data_avail) return {1'b1, srq_on_data_mode, 6'h22};
		if (ms_link) return 8'hA3;
		return 8'h80;
	endfunction

	task automatic cs();
		chk("remote_en", 8'(ren), 8'(remote_en_reg));
		chk("remote", 8'(rem), 8'(remote_reg));
		chk("lockout", 8'(llo), 8'(lockout_reg));
		chk("listen", 8'(lis), 8'(listen_reg));
		chk("talk", 8'(tlk), 8'(talk_reg));
		chk("pp_en", 8'(ppen), 8'(pp_en_reg));
		chk("status", st(), poll_status_byte_reg);
	endtask

	// Send one message, update the model, compare all state
	task automatic msg(input loop_pkg::msg_kind_t k, input logic [7:0] dd);
		bit dc;
		bit na;
		dc = (k == loop_pkg::MSG_DCL) || (k == loop_pkg::MSG_SDC && lis);
		na = (k == loop_pkg::MSG_PPC) && lis;
		ctl.send(k, dd);
		chk("clear", 8'(dc), 8'(clear_reg));
		case (k)
			loop_pkg::MSG_IFC: {lis, tlk} = 2'b00;
			loop_pkg::MSG_REN: ren = 1'b1;
			loop_pkg::MSG_GTL: if (lis) rem = 1'b0;
			loop_pkg::MSG_LLO: if (ren) llo = 1'b1;
			loop_pkg::MSG_NRE: {ren, rem, llo} = 3'b000;
			loop_pkg::MSG_PPE: if (armed && lis && dd[7:4] == 4'h8) begin
				ppen = 1'b1;
				sns = dd[3];
				pbit = dd[2:0];
			end
			loop_pkg::MSG_PPD: if (armed && lis) ppen = 1'b0;
			loop_pkg::MSG_PPU: ppen = 1'b0;
			loop_pkg::MSG_LAD: if (dd[4:0] == own_addr) begin
				lis = 1'b1;
				rem = rem | ren;
			end
			loop_pkg::MSG_UNL: lis = 1'b0;
			loop_pkg::MSG_TAD: tlk = (dd[4:0] == own_addr);
			loop_pkg::MSG_UNT: tlk = 1'b0;
			default: ;
		endcase
		armed = na;
		wt(1);
		cs();
	endtask

	task automatic sp();
		logic [7:0] e;
		e = st();
		ctl.poll(1'b0, 8'h00);
		chk("spoll_valid", 8'h01, 8'(spoll_valid_reg));
		chk("spoll_byte", e, spoll_byte_reg);
		ev = -1;
		wt(2);
		chk("status", st(), poll_status_byte_reg);
	endtask

	task automatic pp(input logic [7:0] b);
		logic [7:0] e;
		logic [7:0] s;
		e = b;
		s = st();
		if (ppen && sns == s[6]) e[pbit] = 1'b1;
		ctl.poll(1'b1, b);
		chk("pp_valid", 8'h01, 8'(pp_out_valid_reg));
		chk("pp_byte", e, pp_byte_out_reg);
		wt(1);
	endtask

	// Data handed over by the instrument; idy pulse expected only in request mode
	task automatic push(input logic e);
		data_push = 1'b1;
		wt(1);
		data_push = 1'b0;
		chk("idy_req", 8'(e), 8'(idy_req_reg));
		wt(1);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h24E8));
		own_addr = 5'($urandom_range(1, 30));
		wt(5);
		nrst = 1'b1;
		cs();
		chk("spoll_byte", 8'h80, spoll_byte_reg);
		chk("pp_byte", 8'h00, pp_byte_out_reg);
		// Parallel poll programming, every response bit with random sense
		for (int b = 0; b < 8; b++) begin
			msg(loop_pkg::MSG_LAD, 8'(own_addr));
			msg(loop_pkg::MSG_PPC, 8'h00);
			msg(loop_pkg::MSG_PPE, ctl.ppe_byte(1'($urandom), 3'(b)));
			pp(8'($urandom));
		end
		msg(loop_pkg::MSG_PPC, 8'h00);
		msg(loop_pkg::MSG_PPD, 8'h00);
		pp(8'($urandom));
		// Event codes raise service request and clear on poll
		for (int i = 0; i < 4; i++) begin
			inst_event_code = (i == 0) ? 6'h04 : (i == 1) ? 6'h06 : (i == 2) ? 6'h07 : 6'h09;
			inst_event_valid = 1'b1;
			wt(1);
			inst_event_valid = 1'b0;
			ev = inst_event_code;
			wt(2);
			chk("status", st(), poll_status_byte_reg);
			pp(8'($urandom));
			sp();
		end
		// State codes persist across polls until the instrument changes
		data_avail = 1'b1;
		wt(2);
		sp();
		sp();
		srq_on_data_mode = 1'b1;
		wt(2);
		sp();
		data_avail = 1'b0;
		wt(2);
		chk("status", 8'h80, poll_status_byte_reg);
		ms_link = 1'b1;
		wt(2);
		sp();
		// Asynchronous request mode ends on any other command
		msg(loop_pkg::MSG_EAR, 8'h00);
		push(1'b1);
		msg(loop_pkg::MSG_GET, 8'h00);
		push(1'b0);
		// Random message storm against the model
		repeat (300) begin
			d = 8'($urandom);
			if ($urandom_range(0, 1)) d[4:0] = own_addr;
			if ($urandom_range(0, 1)) d[7:4] = 4'h8;
			msg(loop_pkg::msg_kind_t'($urandom_range(0, 18)), d);
			if ($urandom_range(0, 3) == 0) pp(8'($urandom));
		end
		// Mid-run reset returns every flag to idle, then a PPE sent right after LAD, with no PPC, must not enable
		ms_link = 1'b0;
		nrst = 1'b0;
		wt(2);
		nrst = 1'b1;
		{ren, rem, llo, lis, tlk, ppen, armed} = 7'h00;
		cs();
		msg(loop_pkg::MSG_LAD, 8'(own_addr));
		msg(loop_pkg::MSG_PPE, ctl.ppe_byte(1'b1, 3'h5));
		summarize();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#3000000;
		n_mismatch++;
		summarize();
	end

	task automatic summarize();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
endmodule
`default_nettype wire
